/* File: include/sweep_pkg.sv */
// Constants and types shared by the parameter sweep sequencer
package sweep_pkg;
	localparam int          NUM_CH      = 2;
	localparam int          VAL_W       = 16;
	localparam int          ADDR_W      = 5;
	localparam int          CLK_HZ      = 20000000;
	localparam int          GRAIN_US    = 200;
	localparam int          GRAIN_CYC   = (GRAIN_US * (CLK_HZ / 1000000));
	localparam logic [11:0] GRAIN_LAST  = 12'(GRAIN_CYC - 1);
	localparam logic [23:0] GRAIN_US_W  = 24'(GRAIN_US);
	localparam logic [23:0] GRAIN_HALF  = 24'(GRAIN_US / 2);
	// Register indices: per channel at {ch, reg}, globals above
	localparam logic [2:0]  REG_CFG     = 3'h0;
	localparam logic [2:0]  REG_START   = 3'h1;
	localparam logic [2:0]  REG_STOP    = 3'h2;
	localparam logic [2:0]  REG_POINTS  = 3'h3;
	localparam logic [2:0]  REG_STEP    = 3'h4;
	localparam logic [2:0]  REG_DWELL   = 3'h5;
	localparam logic [2:0]  REG_TIME    = 3'h6;
	localparam logic [2:0]  REG_RATIO   = 3'h7;
	localparam logic [4:0]  ADR_CTRL    = 5'h10;
	localparam logic [4:0]  ADR_CMD     = 5'h11;
	localparam logic [4:0]  ADR_STATUS  = 5'h12;
	localparam logic [4:0]  ADR_FIX0    = 5'h14;
	// Config field positions
	localparam int          CFG_SWEEP   = 0;
	localparam int          CFG_FREQ    = 1;
	localparam int          CFG_DOWN    = 2;
	localparam int          CFG_ROUND_TRIP_ENABLE   = 3;
	localparam int          CFG_LOG     = 4;
	localparam int          CFG_SHAPEAC = 5;
	localparam int          CFG_W       = 6;
	// Command bits
	localparam int          CMD_LAUNCH  = 0;
	localparam int          CMD_STREAM  = 1;
	localparam int          CMD_ABORT   = 2;
	localparam int          CMD_SRESET  = 3;
	// Reset values
	localparam logic        COUPLE_RST  = 1'b1;
	localparam logic [15:0] POINTS_RST  = 16'h000b;
	localparam logic [15:0] GRAINS_RST  = 16'h0001;
	localparam logic [15:0] RATIO_ONE   = 16'h1000;
	localparam int          RATIO_FRAC  = 12;
	typedef enum logic [1:0] {
		IDLE = 2'b00,
		FWD  = 2'b01,
		REV  = 2'b11
	} run_e;
endpackage

/* File: core/parameter_sweep_sequencer.sv */
// Parameter sweep sequencer with register port and setpoint outputs
`timescale 1ns/100ps
`default_nettype none

//
// Summary of operation
// - Sweep DC amplitude or AC frequency, shape matching
// - All sweeping channels step on same tick
// - Per channel fixed or sweep mode
// - Stop below start gives descending sequence
// - Dwell is whole 200 us grains, minimum one
// - Off-grain dwell stored as nearest valid value
// - Duration write sets dwell as duration over points
// - Step is span over points minus one
// - Points include both endpoints; last equals end
// - Step writes rejected under logarithmic spacing
// - Up runs start to stop, down reversed
// - Round trip repeats turnaround, ends at origin
// - Linear or logarithmic spacing, exact endpoints
// - Logarithmic sweep span must exclude zero
// - Stream start launches sweeps when coupling enabled
// - Direct launch starts sweeps regardless of coupling
// - Per channel busy flag readable
// - Abort stops all, outputs hold last value
// - Busy channel setting change, or stream reset while streaming, aborts
module parameter_sweep_sequencer
	import sweep_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	input  wire logic [ADDR_W-1:0]       regAddr,
	input  wire logic [31:0]             regWrData,
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	output logic      [31:0]             regRdData,
	output logic      [NUM_CH*VAL_W-1:0] setpointOut,
	output logic      [NUM_CH-1:0]       setpointIsFreq,
	output logic      [NUM_CH-1:0]       sweepBusy
);

////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] quantGrains(input logic [23:0] us);
		logic [23:0] g;
		g = (us + GRAIN_HALF) / GRAIN_US_W;
		if (g == 24'h0)
			g = 24'h1;
		if (g > 24'h00ffff)
			g = 24'h00ffff;
		return g[15:0];
	endfunction

	function automatic logic [16:0] spanMag(input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(b) - 17'(a);
		return d[16] ? 17'(-d) : d;
	endfunction

	// Truncating step; the final point is forced so truncation never shows at the end
	function automatic logic [15:0] stepOf(input logic [16:0] span,
		input logic [15:0] pts);
		logic [16:0] q;
		q = (pts < 16'h2) ? 17'h0 : span / 17'(pts - 16'h1);
		return q[15:0];
	endfunction

	function automatic logic signed [15:0] nextPoint(
		input logic signed [15:0] cur, input logic up, input logic lg,
		input logic [15:0] step, input logic [15:0] ratio);
		logic signed [31:0] p;
		logic               grow;
		p = 32'(cur);
		grow = up ^ cur[15];
		if (!lg)
			p = up ? p + 32'(step) : p - 32'(step);
		else if (grow)
			p = (p * $signed({16'h0, ratio})) >>> RATIO_FRAC;
		else
			p = (p <<< RATIO_FRAC) / $signed({16'h0, ratio});
		return p[15:0];
	endfunction

////////////////////////////////////////////////////////////////////////////////
	logic        [CFG_W-1:0]  cfg_r    [NUM_CH];
	logic signed [VAL_W-1:0]  start_r  [NUM_CH];
	logic signed [VAL_W-1:0]  stop_r   [NUM_CH];
	logic signed [VAL_W-1:0]  fix_r    [NUM_CH];
	logic signed [VAL_W-1:0]  cur_r    [NUM_CH];
	logic        [15:0]       points_r [NUM_CH];
	logic        [15:0]       grains_r [NUM_CH];
	logic        [15:0]       ratio_r  [NUM_CH];
	logic        [15:0]       idx_r    [NUM_CH];
	logic        [15:0]       dwell_r  [NUM_CH];
	run_e                     state_r  [NUM_CH];
	logic        [NUM_CH-1:0] valid;
	logic        [11:0]       grainCnt_r;
	logic                     tick;
	logic                     couple_r;
	logic                     streamOn_r;
	logic                     launch;
	logic                     abortAll;
	logic                     chanWr;
	logic                     cmdWr;
	logic                     wrChBusy;
	logic                     chSel;
	logic        [2:0]        regSel;

	assign chanWr   = regWrite && !regAddr[4];
	assign cmdWr    = regWrite && (regAddr == ADR_CMD);
	assign chSel    = regAddr[3];
	assign regSel   = regAddr[2:0];
	assign wrChBusy = chanWr && (state_r[chSel] != IDLE);
	assign tick     = (grainCnt_r == GRAIN_LAST);

	assign launch = cmdWr && (regWrData[CMD_LAUNCH] ||
		(regWrData[CMD_STREAM] && couple_r));

	assign abortAll = (cmdWr && regWrData[CMD_ABORT]) || wrChBusy ||
		(cmdWr && regWrData[CMD_SRESET] && streamOn_r);

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			// Shape match and log span check
			valid[c] = cfg_r[c][CFG_SWEEP] && (points_r[c] >= 16'h2) &&
				(cfg_r[c][CFG_SHAPEAC] == cfg_r[c][CFG_FREQ]) &&
				(!cfg_r[c][CFG_LOG] || (start_r[c] != 16'sh0 &&
				stop_r[c] != 16'sh0 && start_r[c][15] == stop_r[c][15]));
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Grain divider restarts at launch so the first dwell is full length
	always_ff @(posedge core_clk) begin
		if (reset || launch || tick)
			grainCnt_r <= 12'h0;
		else
			grainCnt_r <= grainCnt_r + 12'h1;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			couple_r   <= COUPLE_RST;
			streamOn_r <= 1'b0;
		end else begin
			if (regWrite && regAddr == ADR_CTRL)
				couple_r <= regWrData[0];
			if (cmdWr && regWrData[CMD_SRESET])
				streamOn_r <= 1'b0;
			else if (cmdWr && regWrData[CMD_STREAM])
				streamOn_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int c = 0; c < NUM_CH; c++) begin
				cfg_r[c]    <= '0;
				start_r[c]  <= '0;
				stop_r[c]   <= '0;
				fix_r[c]    <= '0;
				points_r[c] <= POINTS_RST;
				grains_r[c] <= GRAINS_RST;
				ratio_r[c]  <= RATIO_ONE;
			end
		end else begin
			if (regWrite && regAddr[4:1] == ADR_FIX0[4:1])
				fix_r[regAddr[0]] <= regWrData[15:0];
			if (chanWr) begin
				case (regSel)
					REG_CFG:    cfg_r[chSel]   <= regWrData[CFG_W-1:0];
					REG_START:  start_r[chSel] <= regWrData[15:0];
					REG_STOP:   stop_r[chSel]  <= regWrData[15:0];
					REG_POINTS: points_r[chSel] <= regWrData[15:0];
					REG_STEP: begin
						if (!cfg_r[chSel][CFG_LOG] && regWrData[15:0] != 16'h0)
							points_r[chSel] <= 16'(spanMag(start_r[chSel],
								stop_r[chSel]) / 17'(regWrData[15:0]) + 17'h1);
					end
					REG_DWELL: grains_r[chSel] <= quantGrains(regWrData[23:0]);
					REG_TIME: begin
						if (points_r[chSel] != 16'h0)
							grains_r[chSel] <= quantGrains(regWrData[23:0] /
								24'(points_r[chSel]));
					end
					REG_RATIO:  ratio_r[chSel] <= regWrData[15:0];
					default: ;
				endcase
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int c = 0; c < NUM_CH; c++) begin
				state_r[c] <= IDLE;
				cur_r[c]   <= '0;
				idx_r[c]   <= '0;
				dwell_r[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				logic signed [15:0] first;
				logic signed [15:0] last;
				logic               fin;
				logic               up;
				first = cfg_r[c][CFG_DOWN] ? stop_r[c] : start_r[c];
				last  = cfg_r[c][CFG_DOWN] ? start_r[c] : stop_r[c];
				if (state_r[c] == REV) begin
					first = last;
					last  = cfg_r[c][CFG_DOWN] ? stop_r[c] : start_r[c];
				end
				up  = (last > first);
				fin = (idx_r[c] == points_r[c] - 16'h2);
				// Abort keeps the last applied value
				if (abortAll) begin
					state_r[c] <= IDLE;
				end else if (launch && valid[c]) begin
					state_r[c] <= FWD;
					cur_r[c]   <= cfg_r[c][CFG_DOWN] ? stop_r[c] : start_r[c];
					idx_r[c]   <= 16'h0;
					dwell_r[c] <= 16'h0;
				end else if (tick && state_r[c] != IDLE) begin
					if (dwell_r[c] + 16'h1 < grains_r[c]) begin
						dwell_r[c] <= dwell_r[c] + 16'h1;
					end else begin
						dwell_r[c] <= 16'h0;
						if (idx_r[c] == points_r[c] - 16'h1) begin
							idx_r[c] <= 16'h0;
							// Turnaround value held a second step
							if (state_r[c] == FWD && cfg_r[c][CFG_ROUND_TRIP_ENABLE])
								state_r[c] <= REV;
							else
								state_r[c] <= IDLE;
						end else begin
							idx_r[c] <= idx_r[c] + 16'h1;
							if (fin)
								cur_r[c] <= last;
							else
								cur_r[c] <= nextPoint(cur_r[c], up,
									cfg_r[c][CFG_LOG],
									stepOf(spanMag(first, last), points_r[c]),
									ratio_r[c]);
						end
					end
				end
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Fixed channels show their static setpoint; swept ones hold last value
	always_ff @(posedge core_clk) begin
		if (reset) begin
			setpointOut    <= '0;
			setpointIsFreq <= '0;
			sweepBusy      <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				setpointOut[c*VAL_W +: VAL_W] <= cfg_r[c][CFG_SWEEP] ?
					cur_r[c] : fix_r[c];
				setpointIsFreq[c] <= cfg_r[c][CFG_FREQ];
				sweepBusy[c]      <= (state_r[c] != IDLE);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			regRdData <= 32'h0;
		end else if (!regRead) begin
			regRdData <= 32'h0;
		end else if (!regAddr[4]) begin
			case (regSel)
				REG_CFG:    regRdData <= 32'(cfg_r[chSel]);
				REG_START:  regRdData <= 32'(unsigned'(start_r[chSel]));
				REG_STOP:   regRdData <= 32'(unsigned'(stop_r[chSel]));
				REG_POINTS: regRdData <= 32'(points_r[chSel]);
				REG_STEP:   regRdData <= 32'(stepOf(spanMag(start_r[chSel],
					stop_r[chSel]), points_r[chSel]));
				REG_DWELL:  regRdData <= 32'(grains_r[chSel]) * 32'(GRAIN_US);
				REG_TIME:   regRdData <= 32'(grains_r[chSel]) * 32'(GRAIN_US) *
					32'(points_r[chSel]);
				REG_RATIO:  regRdData <= 32'(ratio_r[chSel]);
				default:    regRdData <= 32'h0;
			endcase
		end else begin
			case (regAddr)
				ADR_CTRL:   regRdData <= 32'(couple_r);
				ADR_STATUS: regRdData <= {15'h0, streamOn_r, 14'h0,
					state_r[1] != IDLE, state_r[0] != IDLE};
				ADR_FIX0:   regRdData <= 32'(unsigned'(fix_r[0]));
				5'h15:      regRdData <= 32'(unsigned'(fix_r[1]));
				default:    regRdData <= 32'h0;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
	grain_range_a: assert property (@(posedge core_clk) disable iff (reset)
		grainCnt_r <= GRAIN_LAST) else $error("grain counter overrun");

	generate
		for (genvar g = 0; g < NUM_CH; g++) begin : chk
			dwell_nonzero_a: assert property (@(posedge core_clk) disable iff (reset)
				grains_r[g] != 16'h0) else $error("zero dwell");
			step_rejected_a: assert property (@(posedge core_clk) disable iff (reset)
				(chanWr && chSel == g && regSel == REG_STEP && cfg_r[g][CFG_LOG])
				|=> $stable(points_r[g])) else $error("step taken in log mode");
			launch_busy_a: assert property (@(posedge core_clk) disable iff (reset)
				(launch && valid[g] && !abortAll) |=> state_r[g] == FWD
				##1 sweepBusy[g]) else $error("launch did not start");
			abort_idle_a: assert property (@(posedge core_clk) disable iff (reset)
				abortAll |=> state_r[g] == IDLE && $stable(cur_r[g]))
				else $error("abort failed");
			step_on_tick_a: assert property (@(posedge core_clk) disable iff (reset)
				(state_r[g] != IDLE && !launch && !$past(tick)) |-> $stable(cur_r[g])
				or $past(launch)) else $error("step off tick");
			end_on_tick_a: assert property (@(posedge core_clk) disable iff (reset)
				($past(state_r[g]) != IDLE && state_r[g] == IDLE) |->
				$past(tick) || $past(abortAll)) else $error("end off tick");
			fixed_out_a: assert property (@(posedge core_clk) disable iff (reset)
				!cfg_r[g][CFG_SWEEP] |=> setpointOut[g*VAL_W +: VAL_W] ==
				$past(fix_r[g])) else $error("fixed output wrong");
			invalid_idle_a: assert property (@(posedge core_clk) disable iff (reset)
				($past(state_r[g]) == IDLE && !$past(valid[g])) |-> state_r[g] == IDLE)
				else $error("invalid sweep started");
		end
	endgenerate

endmodule

`default_nettype wire

/* File: dv/source_setpoint_model.sv */
// Far-side model: setpoint inputs that note when each channel changes
`timescale 1ns/100ps
`default_nettype none
module source_setpoint_model
	import sweep_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic [NUM_CH*VAL_W-1:0] setpointOut,
	output logic      [31:0]             chgAt [NUM_CH]
);
	logic [NUM_CH*VAL_W-1:0] prev_r;
	logic [31:0]             cyc_r = '0;
	// Change stamps let the bench measure dwell to the exact cycle
	always_ff @(posedge core_clk) begin
		prev_r <= setpointOut;
		cyc_r  <= cyc_r + 32'h1;
		for (int c = 0; c < NUM_CH; c++)
			if (setpointOut[c*VAL_W+:VAL_W] !== prev_r[c*VAL_W+:VAL_W])
				chgAt[c] <= cyc_r;
	end
endmodule
`default_nettype wire

/* File: dv/parameter_sweep_sequencer_tb.sv */
// Self-checking bench for the parameter sweep sequencer
`timescale 1ns/100ps
`default_nettype none
module parameter_sweep_sequencer_tb;
	import sweep_pkg::*;
	logic                    core_clk = 1'b0;
	logic                    reset = 1'b1;
	logic [ADDR_W-1:0]       regAddr = '0;
	logic [31:0]             regWrData = '0;
	logic                    regWrite = 1'b0;
	logic                    regRead = 1'b0;
	logic [31:0]             regRdData;
	logic [NUM_CH*VAL_W-1:0] setpointOut;
	logic [NUM_CH-1:0]       setpointIsFreq;
	logic [NUM_CH-1:0]       sweepBusy;
	logic [31:0]             chgAt [NUM_CH];
	logic [15:0]             rnd = 16'h003f;
	int                      bad_count = 0;
	int                      checked = 0;
	int                      cs [NUM_CH];
	int                      ce [NUM_CH];
	int                      cn [NUM_CH];
	int                      cm [NUM_CH];
	always #25 core_clk = ~core_clk;
	parameter_sweep_sequencer DUT (
		.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .setpointOut(setpointOut),
		.setpointIsFreq(setpointIsFreq), .sweepBusy(sweepBusy));
	source_setpoint_model sink (
		.core_clk(core_clk), .setpointOut(setpointOut), .chgAt(chgAt));
	////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [4:0] ra(input int c, input logic [2:0] r);
		return {2'(c), r};
	endfunction
	function automatic logic [31:0] spv(input int c);
		return {16'h0, setpointOut[c*VAL_W+:VAL_W]};
	endfunction
	// Mode bits in cm: swept, down, round trip, log (doubling ratio)
	function automatic logic [31:0] ex(input int c, input int k);
		int n, j, a, b;
		n = cn[c];
		j = (k < n) ? k : n - 1;
		if (cm[c][2] && k >= n)
			j = (k < 2 * n) ? 2 * n - 1 - k : 0;
		a = cm[c][1] ? ce[c] : cs[c];
		b = cm[c][1] ? cs[c] : ce[c];
		if (cm[c][3])
			return {16'h0, 16'(a << j)};
		return {16'h0, 16'(a + (b - a) * j / (n - 1))};
	endfunction
	task automatic close_out();
		if (bad_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge core_clk);
		regAddr   <= a;
		regWrData <= v;
		regWrite  <= 1'b1;
		@(posedge core_clk);
		regWrite  <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic follow(input int steps, input int dw);
		logic [31:0] d, pc, m;
		tick(dw * 2000);
		for (int k = 0; k < steps; k++) begin
			m = '0;
			for (int c = 0; c < NUM_CH; c++)
				m[c] = cm[c][0] && k < cn[c] * (cm[c][2] ? 2 : 1);
			chk("busy", 32'(sweepBusy), m);
			for (int c = 0; c < NUM_CH; c++)
				if (cm[c][0])
					chk("point", spv(c), ex(c, k));
				else
					chk("fixed", spv(c), 32'h1234);
			if (k > 0 && k < cn[0])
				chk("dwell", chgAt[0] - pc, 32'(dw * 4000));
			if (cm[1][0] && k > 0 && k < cn[0])
				chk("sync", chgAt[1], chgAt[0]);
			pc = chgAt[0];
			if (k == 0) begin
				rd(ADR_STATUS, d);
				chk("status", d & 32'h3, m);
			end
			tick(dw * 4000);
		end
		for (int i = 0; i < 9000 && sweepBusy !== '0; i++)
			@(posedge core_clk);
		if (sweepBusy !== '0) begin
			bad_count++;
			close_out();
		end
		for (int c = 0; c < NUM_CH; c++)
			if (cm[c][0])
				chk("hold", spv(c), ex(c, 99));
	endtask
	// Launch, let point one land, then cut the sweep some way
	task automatic cut(input logic [4:0] a, input logic [31:0] v);
		wr(ADR_CMD, 32'h1);
		tick(6000);
		wr(a, v);
		tick(10);
		chk("abort", 32'(sweepBusy), 32'h0);
		chk("held", spv(0), 32'h4);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		int g, s, k, a;
		tick(2);
		reset <= 1'b0;
		rd(ADR_CTRL, d);
		chk("couple", d, 32'h1);
		rd(ra(0, REG_POINTS), d);
		chk("points", d, 32'hb);
		rd(ra(0, REG_DWELL), d);
		chk("dwell", d, 32'(GRAIN_US));
		wr(5'h13, 32'h5);
		rd(5'h13, d);
		chk("unmapped", d, 32'h0);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			g = rnd[2:0];
			a = (rnd[15] && g > 0) ? -rnd[9:4] : rnd[9:4];
			wr(ra(1, REG_DWELL), 32'(g * 200 + a));
			rd(ra(1, REG_DWELL), d);
			chk("quant", d, 32'((g == 0 ? 1 : g) * 200));
		end
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			s = rnd[2:0] + 1;
			k = rnd[6:4] + 1;
			a = rnd[12:8];
			wr(ra(0, REG_START), 32'(a));
			wr(ra(0, REG_STOP), 32'(rnd[15] ? a - s * k : a + s * k));
			wr(ra(0, REG_STEP), 32'(s));
			rd(ra(0, REG_POINTS), d);
			chk("points", d, 32'(k + 1));
			rd(ra(0, REG_STEP), d);
			chk("step", d, 32'(s));
		end
		wr(ra(0, REG_CFG), 32'h10);
		wr(ra(0, REG_STEP), 32'h1);
		rd(ra(0, REG_POINTS), d);
		chk("logstep", d, 32'(k + 1));
		wr(ra(0, REG_POINTS), 32'h4);
		wr(ra(0, REG_TIME), 32'd2400);
		rd(ra(0, REG_DWELL), d);
		chk("time", d, 32'd600);
		wr(ra(0, REG_DWELL), 32'd200);
		wr(ra(1, REG_DWELL), 32'd200);
		// Shape mismatch on ch0, zero inside the log span on ch1
		wr(ra(0, REG_CFG), 32'h3);
		wr(ra(1, REG_CFG), 32'h11);
		wr(ra(1, REG_STOP), 32'h8);
		wr(ADR_CMD, 32'h1);
		tick(10);
		chk("shape", 32'(sweepBusy[0]), 32'h0);
		chk("logzero", 32'(sweepBusy[1]), 32'h0);
		cs = '{2, 10};
		ce = '{6, 14};
		cn = '{3, 3};
		cm = '{3, 5};
		foreach (cs[c]) begin
			wr(ra(c, REG_START), 32'(cs[c]));
			wr(ra(c, REG_STOP), 32'(ce[c]));
			wr(ra(c, REG_POINTS), 32'(cn[c]));
		end
		wr(ra(0, REG_CFG), 32'h5);
		wr(ra(1, REG_CFG), 32'h2b);
		wr(ADR_CMD, 32'h1);
		follow(6, 1);
		chk("isfreq", 32'(setpointIsFreq), 32'h2);
		cs = '{1, 0};
		ce = '{4, 0};
		cm = '{9, 0};
		wr(ra(0, REG_CFG), 32'h11);
		wr(ra(0, REG_START), 32'h1);
		wr(ra(0, REG_STOP), 32'h4);
		wr(ra(0, REG_RATIO), 32'h2000);
		wr(ra(0, REG_DWELL), 32'd400);
		wr(ra(1, REG_CFG), 32'h0);
		wr(ADR_FIX0 + 5'h1, 32'h1234);
		wr(ADR_CMD, 32'h2);
		follow(3, 2);
		wr(ra(0, REG_CFG), 32'h5);
		wr(ra(0, REG_STOP), 32'h5);
		wr(ra(0, REG_POINTS), 32'h4);
		wr(ra(0, REG_DWELL), 32'd200);
		cut(ADR_CMD, 32'h4);
		cut(ra(0, REG_RATIO), 32'h1000);
		wr(ADR_CTRL, 32'h0);
		wr(ADR_CMD, 32'h2);
		tick(10);
		chk("uncoupled", 32'(sweepBusy), 32'h0);
		cut(ADR_CMD, 32'h8);
		wr(ADR_CMD, 32'h5);
		tick(10);
		chk("abortwins", 32'(sweepBusy), 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
